// [core/smc_cfg.svh]
// constants for the stepper mode control block
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
// ============================================================
// position counter
`define SMC_POS_W        9
`define SMC_POS_HOME     9'h000
`define SMC_POS_LAST     9'h1FF
`define SMC_RES_W        4
// ============================================================
// register port
`define SMC_ADDR_W       4
`define SMC_ADDR_CFG     4'h0
`define SMC_ADDR_STAT    4'h1
`define SMC_ADDR_POS     4'h2
`define SMC_CFG_RESET    32'h0000_0000
// ============================================================
// gate drive patterns per quadrant: {b2,a2,b1,a1} high side on
`define SMC_GATE_OFF     4'h0
`define SMC_TBL_W        9
`endif

// [core/smc_pkg.sv]
// types for the stepper mode control block
package smc_pkg;
  typedef enum logic [1:0] {
    SMC_STANDBY  = 2'b00,
    SMC_HOME     = 2'b01,
    SMC_RUN      = 2'b10
  } smc_state_e;
endpackage : smc_pkg

// [core/smc_steps.sv]
// maps a resolution code to steps per quarter cycle, registered
module smc_steps (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] res,
  output logic      [8:0] steps
);
  logic [8:0] steps_r;
  logic [8:0] steps_nxt;
  always_comb begin
    case (res)
      4'h0: steps_nxt = 9'd2;
      4'h1: steps_nxt = 9'd4;
      4'h2: steps_nxt = 9'd8;
      4'h3: steps_nxt = 9'd16;
      4'h4: steps_nxt = 9'd32;
      4'h5: steps_nxt = 9'd64;
      4'h6: steps_nxt = 9'd128;
      4'h7: steps_nxt = 9'd3;
      4'h8: steps_nxt = 9'd6;
      4'h9: steps_nxt = 9'd12;
      4'hA: steps_nxt = 9'd36;
      4'hB: steps_nxt = 9'd5;
      4'hC: steps_nxt = 9'd10;
      4'hD: steps_nxt = 9'd20;
      4'hE: steps_nxt = 9'd50;
      default: steps_nxt = 9'd100;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      steps_r <= 9'd2;
    end else begin
      steps_r <= steps_nxt;
    end
  end
  assign steps = steps_r;
endmodule // smc_steps

// [core/smc_sync.sv]
// two-flop synchroniser for a group of pins
module smc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end
  assign q = q_r;
endmodule // smc_sync

// [core/smc_top.sv]
// system-mode control and step sequencer of a stepper pre-driver
// ============================================================
// Notes on behaviour
// - sleep low: standby, gates off, reset sequencer; resolution kept.
// - sleep high: active, excite home position.
// - advance edge steps in selected direction.
// - home reset high holds home position.
// - first advance after home release moves.
// - home flag driven low at home.
// - output disable high turns gates off.
// - sequencer keeps stepping while outputs disabled.
// - outputs active only sleep high, disable low.
// - direction low clockwise, high counter-clockwise.
// - steps per quarter from resolution bits.
`include "smc_cfg.svh"
module smc_top
  import smc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        sleep_control_pin,
  input  wire logic        home_reset_pin,
  input  wire logic        output_disable_pin,
  input  wire logic        step_advance_pin,
  input  wire logic        direction_select_pin,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic      [3:0]  high_side_gate_drive,
  output logic      [3:0]  low_side_gate_drive,
  output logic             home_position_flag_o,
  output logic             home_position_flag_oe,
  output logic      [1:0]  quadrant,
  output logic      [8:0]  step_in_quadrant
);
  // ============================================================
  // pin synchronisers
  logic [4:0] pins_s;
  smc_sync #(.W(5)) smc_sync_inst (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({sleep_control_pin, home_reset_pin, output_disable_pin,
              step_advance_pin, direction_select_pin}),
    .q      (pins_s)
  );
  logic sleep_s, home_s, dis_s, adv_s, dir_s;
  assign sleep_s = pins_s[4];
  assign home_s  = pins_s[3];
  assign dis_s   = pins_s[2];
  assign adv_s   = pins_s[1];
  assign dir_s   = pins_s[0];

  // ============================================================
  // register port: cfg holds resolution code in bits 3:0
  logic [3:0]  res_r, res_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [8:0]  steps_q;
  smc_steps smc_steps_inst (
    .clk    (clk),
    .arst_n (arst_n),
    .res    (res_r),
    .steps  (steps_q)
  );

  // ============================================================
  // sequencer state
  smc_state_e  state_r, state_nxt;
  logic        adv_prev_r, adv_prev_nxt;
  logic [1:0]  quad_r, quad_nxt;
  logic [8:0]  pos_r, pos_nxt;
  logic        adv_edge;
  assign adv_edge = adv_s & ~adv_prev_r;

  always_comb begin
    state_nxt    = state_r;
    adv_prev_nxt = adv_s;
    quad_nxt     = quad_r;
    pos_nxt      = pos_r;
    // sleep low is synchronous reset of state, edge detector, quadrant and position as well
    if (!sleep_s) begin
      state_nxt    = SMC_STANDBY;
      adv_prev_nxt = 1'b0;
      quad_nxt     = 2'b00;
      pos_nxt      = `SMC_POS_HOME;
    end else begin
      case (state_r)
        SMC_STANDBY: begin
          state_nxt = home_s ? SMC_HOME : SMC_RUN;
          quad_nxt  = 2'b00;
          pos_nxt   = `SMC_POS_HOME;
        end
        SMC_HOME: begin
          quad_nxt = 2'b00;
          pos_nxt  = `SMC_POS_HOME;
          if (!home_s) begin
            state_nxt = SMC_RUN;
          end
        end
        default: begin
          if (home_s) begin
            state_nxt = SMC_HOME;
            quad_nxt  = 2'b00;
            pos_nxt   = `SMC_POS_HOME;
          end else if (adv_edge) begin
            if (!dir_s) begin
              if (pos_r + 9'd1 >= steps_q) begin
                pos_nxt  = `SMC_POS_HOME;
                quad_nxt = quad_r + 2'd1;
              end else begin
                pos_nxt = pos_r + 9'd1;
              end
            end else begin
              if (pos_r == `SMC_POS_HOME) begin
                pos_nxt  = steps_q - 9'd1;
                quad_nxt = quad_r - 2'd1;
              end else begin
                pos_nxt = pos_r - 9'd1;
              end
            end
          end
        end
      endcase
    end
  end

  // ============================================================
  // outputs: quadrant picks coil polarity, full-bridge pattern
  logic [3:0] hs_nxt, ls_nxt, hs_r, ls_r;
  logic       flag_nxt, flag_r;
  logic       drive_on;
  assign drive_on = sleep_s & ~dis_s & (state_nxt != SMC_STANDBY);
  always_comb begin
    hs_nxt = `SMC_GATE_OFF;
    ls_nxt = `SMC_GATE_OFF;
    if (drive_on) begin
      // bit order {2B,2A,1B,1A}; ch1 sign cos, ch2 sign sin
      case (quad_nxt)
        2'd0: begin hs_nxt = 4'b0101; ls_nxt = 4'b1010; end
        2'd1: begin hs_nxt = 4'b0110; ls_nxt = 4'b1001; end
        2'd2: begin hs_nxt = 4'b1010; ls_nxt = 4'b0101; end
        default: begin hs_nxt = 4'b1001; ls_nxt = 4'b0110; end
      endcase
    end
    // home is position zero of quadrant zero, shown only while active
    flag_nxt = (state_nxt != SMC_STANDBY) && (quad_nxt == 2'd0)
               && (pos_nxt == `SMC_POS_HOME);
  end

  always_comb begin
    res_nxt   = res_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr && reg_addr == `SMC_ADDR_CFG) begin
      res_nxt = reg_wdata[3:0];
    end
    if (reg_rd) begin
      if (reg_addr == `SMC_ADDR_CFG) begin
        rdata_nxt = {28'h000_0000, res_r};
      end else if (reg_addr == `SMC_ADDR_STAT) begin
        rdata_nxt = {26'h000_0000, flag_r, dis_s, home_s, sleep_s, state_r};
      end else if (reg_addr == `SMC_ADDR_POS) begin
        rdata_nxt = {21'h00_0000, quad_r, pos_r};
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= SMC_STANDBY;
      adv_prev_r <= 1'b0;
      quad_r     <= 2'b00;
      pos_r      <= `SMC_POS_HOME;
      hs_r       <= `SMC_GATE_OFF;
      ls_r       <= `SMC_GATE_OFF;
      flag_r     <= 1'b0;
      res_r      <= 4'h0;
      rdata_r    <= 32'h0000_0000;
    end else begin
      state_r    <= state_nxt;
      adv_prev_r <= adv_prev_nxt;
      quad_r     <= quad_nxt;
      pos_r      <= pos_nxt;
      hs_r       <= hs_nxt;
      ls_r       <= ls_nxt;
      flag_r     <= flag_nxt;
      res_r      <= res_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign reg_rdata             = rdata_r;
  assign high_side_gate_drive  = hs_r;
  assign low_side_gate_drive   = ls_r;
  assign home_position_flag_o  = 1'b0;
  assign home_position_flag_oe = flag_r;
  assign quadrant              = quad_r;
  assign step_in_quadrant      = pos_r;
endmodule // smc_top

// [verification/smc_host.sv]
// host controller model that sends step pulses
module smc_host (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       go,
  input  wire logic [3:0] count,
  output logic            step,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left_r, left_nxt;
  logic [2:0] ph_r, ph_nxt;
  // ============================================================
  // four cycles high, four low, so the sync never misses an edge
  always_comb begin
    left_nxt = left_r;
    ph_nxt = ph_r + 3'h1;
    if (go) begin
      left_nxt = count;
      ph_nxt = 3'h0;
    end else if (ph_r == 3'h7 && left_r != 4'h0) begin
      left_nxt = left_r - 4'h1;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      left_r <= 4'h0;
      ph_r <= 3'h0;
    end else begin
      left_r <= left_nxt;
      ph_r <= ph_nxt;
    end
  end
  assign step = (left_r != 4'h0) && ph_r[2];
  assign busy = left_r != 4'h0;
endmodule // smc_host

// [verification/smc_props.sv]
// checker for the stepper mode control outputs
module smc_props (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       sleep_control_pin,
  input wire logic       home_reset_pin,
  input wire logic       output_disable_pin,
  input wire logic       step_advance_pin,
  input wire logic [3:0] high_side_gate_drive,
  input wire logic [3:0] low_side_gate_drive,
  input wire logic       home_position_flag_o,
  input wire logic       home_position_flag_oe,
  input wire logic [1:0] quadrant,
  input wire logic [8:0] step_in_quadrant
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [10:0] pos = {quadrant, step_in_quadrant};
  wire [7:0]  gates = {high_side_gate_drive, low_side_gate_drive};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ============================================================
  // repetition lengths cover the two sync flops plus the output register
  sequence s_off; !sleep_control_pin [*4]; endsequence
  sequence s_run; (sleep_control_pin && !output_disable_pin) [*5]; endsequence
  sequence s_hold; (sleep_control_pin && home_reset_pin) [*5]; endsequence
  sequence s_idle; (sleep_control_pin && !home_reset_pin && !step_advance_pin) [*5]; endsequence
  chk_standby_gates: assert property (s_off |-> gates == 8'h00)
    else $error("gates on in standby");
  chk_standby_home: assert property (s_off |-> pos == 11'h000)
    else $error("position kept in standby");
  chk_disable_off: assert property (output_disable_pin [*4] |-> gates == 8'h00)
    else $error("gates on while disabled");
  chk_active_drive: assert property (s_run |-> high_side_gate_drive != 4'h0)
    else $error("gates idle while active");
  chk_home_hold: assert property (s_hold |-> pos == 11'h000 && home_position_flag_oe)
    else $error("home not held");
  chk_flag_home: assert property (home_position_flag_oe |-> pos == 11'h000)
    else $error("flag away from home");
  chk_flag_low: assert property (home_position_flag_o == 1'b0)
    else $error("flag driven high");
  // gates and flag come from the same edge, so home with drive on must show the flag
  chk_flag_shown: assert property (pos == 11'h000 && gates != 8'h00 |-> home_position_flag_oe)
    else $error("flag missing at home");
  chk_step_idle: assert property (s_idle |=> $stable(pos))
    else $error("position moved without advance");
endmodule // smc_props

// [verification/stepper_mode_control_test.sv]
// self-checking bench for the stepper mode control block
module stepper_mode_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, sleep_control_pin = 1'b0, home_reset_pin = 1'b0;
  logic output_disable_pin = 1'b0, direction_select_pin = 1'b0, go = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, step_advance_pin, busy;
  logic [3:0] count = 4'h0, reg_addr = 4'h0, high_side_gate_drive, low_side_gate_drive;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic home_position_flag_o, home_position_flag_oe;
  logic [1:0] quadrant;
  logic [8:0] step_in_quadrant;
  int failures = 0, samples_checked = 0;
  wire [10:0] pos = {quadrant, step_in_quadrant};
  wire [7:0] gates = {high_side_gate_drive, low_side_gate_drive};
  always #2.5 clk = ~clk;
  smc_top smc_top_inst (.clk, .arst_n, .sleep_control_pin, .home_reset_pin,
    .output_disable_pin, .step_advance_pin, .direction_select_pin, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .high_side_gate_drive, .low_side_gate_drive,
    .home_position_flag_o, .home_position_flag_oe, .quadrant, .step_in_quadrant);
  smc_host smc_host_inst (.clk, .arst_n, .go, .count, .step(step_advance_pin), .busy);
  // ============================================================
  // helpers
  task check(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task stop_test;
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // pins settle through the sync before anything is looked at
  task pins(input logic sl, input logic hm, input logic ds, input logic dr);
    @(posedge clk);
    sleep_control_pin <= sl;
    home_reset_pin <= hm;
    output_disable_pin <= ds;
    direction_select_pin <= dr;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task pulses(input logic [3:0] n);
    int i;
    @(posedge clk);
    go <= 1'b1;
    count <= n;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (i = 0; i < 200 && busy === 1'b1; i++) @(posedge clk);
    repeat (6) @(posedge clk);
    #1;
    check("host done", busy, 1'b0);
  endtask
  task reg_cycle(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  // ============================================================
  // scenarios
  task t_wake;
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    check("standby gates", gates, 8'h00);
    check("standby flag", home_position_flag_oe, 1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    check("home gates", gates, 8'h5A);
    check("home flag", home_position_flag_oe, 1'b1);
  endtask
  task t_steps;
    pulses(4'h3);
    check("cw pos", pos, 11'h201);
    check("cw gates", gates, 8'h69);
    check("away flag", home_position_flag_oe, 1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b1);
    pulses(4'h4);
    check("ccw pos", pos, 11'h601);
    check("ccw gates", gates, 8'h96);
  endtask
  task t_home;
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    pulses(4'h2);
    check("held pos", pos, 11'h000);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    pulses(4'h1);
    check("first step", pos, 11'h001);
  endtask
  task t_disable;
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    check("off gates", gates, 8'h00);
    pulses(4'h2);
    check("off pos", pos, 11'h201);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    check("on gates", gates, 8'h69);
  endtask
  task t_res;
    reg_cycle(1'b0, 4'h2, 32'h0000_0000);
    check("pos reg", reg_rdata, 32'h0000_0201);
    reg_cycle(1'b0, 4'h1, 32'h0000_0000);
    check("stat reg", reg_rdata, 32'h0000_0006);
    reg_cycle(1'b1, 4'h0, 32'h0000_0001);
    // status is read only, so this write must not reach the resolution code
    reg_cycle(1'b1, 4'h1, 32'h0000_000F);
    reg_cycle(1'b0, 4'h0, 32'h0000_0000);
    check("cfg", reg_rdata, 32'h0000_0001);
    @(posedge clk);
    #1;
    check("cfg gone", reg_rdata, 32'h0000_0000);
    reg_cycle(1'b0, 4'hF, 32'h0000_0000);
    check("unmapped", reg_rdata, 32'h0000_0000);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    pulses(4'h5);
    check("fine pos", pos, 11'h201);
    // three steps per quarter: a count that is not a power of two
    reg_cycle(1'b1, 4'h0, 32'h0000_0007);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    pulses(4'h5);
    check("third pos", pos, 11'h202);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    check("sleep pos", pos, 11'h000);
    check("sleep gates", gates, 8'h00);
    check("sleep flag", home_position_flag_oe, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_wake;
    t_steps;
    t_home;
    t_disable;
    t_res;
    stop_test;
  end
  initial begin
    #100us;
    failures++;
    stop_test;
  end
endmodule // stepper_mode_control_test
bind smc_top smc_props smc_props_inst (.clk, .arst_n, .sleep_control_pin, .home_reset_pin,
  .output_disable_pin, .step_advance_pin, .high_side_gate_drive, .low_side_gate_drive,
  .home_position_flag_o, .home_position_flag_oe, .quadrant, .step_in_quadrant);
